// ===== src/sae_pkg.sv
package sae_pkg;

  // Word and field widths.
  localparam int WORD_W = 30;
  localparam int IDX_W  = 15;
  localparam int NUM_IDX = 8;

  // Operation codes, two octal digits packed into six bits.
  localparam logic [5:0] OP_RSH_S  = 6'h02;
  localparam logic [5:0] OP_RSH_P  = 6'h03;
  localparam logic [5:0] OP_CMP    = 6'h04;
  localparam logic [5:0] OP_LSH_E  = 6'h05;
  localparam logic [5:0] OP_LSH_S  = 6'h06;
  localparam logic [5:0] OP_LSH_P  = 6'h07;
  localparam logic [5:0] OP_ENT_E  = 6'h08;
  localparam logic [5:0] OP_ENT_S  = 6'h09;
  localparam logic [5:0] OP_ENT_X  = 6'h0A;
  localparam logic [5:0] OP_EXTF   = 6'h0B;
  localparam logic [5:0] OP_STO_E  = 6'h0C;
  localparam logic [5:0] OP_STO_S  = 6'h0D;
  localparam logic [5:0] OP_STO_X  = 6'h0E;
  localparam logic [5:0] OP_STO_C  = 6'h0F;
  localparam logic [5:0] OP_ADD    = 6'h10;
  localparam logic [5:0] OP_SUB    = 6'h11;
  localparam logic [5:0] OP_MUL    = 6'h12;
  localparam logic [5:0] OP_DIV    = 6'h13;
  localparam logic [5:0] OP_RADD   = 6'h14;
  localparam logic [5:0] OP_RSUB   = 6'h15;
  localparam logic [5:0] OP_ADD_E  = 6'h16;
  localparam logic [5:0] OP_SUB_E  = 6'h17;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OPER = 8'h04;
  localparam logic [7:0] OFS_SUM  = 8'h08;
  localparam logic [7:0] OFS_EXT  = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MEMW = 8'h14;
  localparam logic [2:0] IDX_PAGE = 3'h1;

  // Status bit positions.
  localparam int ST_SKIP  = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_BUSY  = 2;

  // Special field values.
  localparam logic [2:0] K_FULL = 3'h3;
  localparam logic [2:0] K_ZERO = 3'h0;
  localparam logic [2:0] K_FOUR = 3'h4;

  // Command word as written to the control register.
  typedef struct packed {
    logic [2:0] k;
    logic [2:0] j;
    logic [5:0] op;
  } sae_cmd_type;

  // Ones' complement add with end-around carry.
  function automatic logic [29:0] oc_add(input logic [29:0] a, input logic [29:0] b);
    logic [30:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[29:0] + {29'h0, s[30]};
  endfunction : oc_add

  // Signed value of a ones' complement word.
  function automatic logic signed [30:0] oc_val(input logic [29:0] x);
    return x[29] ? -$signed({2'b00, ~x[28:0]}) : $signed({2'b00, x[28:0]});
  endfunction : oc_val

endpackage : sae_pkg

// ===== src/sae_unit.sv
module sae_unit
  import sae_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [1:0]  peer_active,
  input  wire logic [29:0] in_word,
  output logic             in_ack,
  output logic             ef_strobe,
  output logic      [29:0] ef_word,
  output logic      [2:0]  chan_sel,
  output logic             mem_we,
  output logic      [14:0] mem_addr,
  output logic      [29:0] mem_wdata,
  output logic             skip,
  output logic             done
);

  logic [1:0]  act_s1;            // First stage, peer activity.
  logic [1:0]  act_s2;            // Second stage, safe to use.
  logic [29:0] inw_s1;            // First stage, channel word.
  logic [29:0] inw_s2;            // Second stage, safe to use.
  logic        wr_pend;           // A write data phase is due.
  logic [7:0]  wr_addr;           // Address of the pending write.
  logic [29:0] sum;               // Sum register.
  logic [29:0] ext;               // Low extension register.
  logic [29:0] oper;              // Effective operand.
  sae_cmd_type cmd;               // Current command.
  logic        go;                // Execute in this cycle.
  logic [2:0]  stat;              // Skip and fault of last command, held; busy set one cycle per control write.
  logic [14:0] idx [NUM_IDX];     // Index file.

  // Pins from outside pass two flip-flops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_s1 <= 2'h0;
      act_s2 <= 2'h0;
      inw_s1 <= 30'h0;
      inw_s2 <= 30'h0;
    end else if (ce) begin
      act_s1 <= peer_active;
      act_s2 <= act_s1;
      inw_s1 <= in_word;
      inw_s2 <= inw_s1;
    end
  end

  // Bus decode: address phase taken when selected and ready.
  wire       addr_ok = hsel && htrans[1] && hready;
  wire [7:0] ra      = haddr[7:0];
  wire       hit     = haddr[31:8] == 24'h0;
  wire       we_ctrl = wr_pend && wr_addr == OFS_CTRL;
  wire       we_oper = wr_pend && wr_addr == OFS_OPER;
  wire       we_sum  = wr_pend && wr_addr == OFS_SUM;
  wire       we_ext  = wr_pend && wr_addr == OFS_EXT;
  wire       we_idx  = wr_pend && wr_addr[7:5] == IDX_PAGE;

  // Read selection; unmapped words read as zero.
  wire [31:0] rd_word =
    !hit                  ? 32'h0 :
    ra == OFS_CTRL        ? {20'h0, cmd} :
    ra == OFS_OPER        ? {2'h0, oper} :
    ra == OFS_SUM         ? {2'h0, sum} :
    ra == OFS_EXT         ? {2'h0, ext} :
    ra == OFS_STAT        ? {29'h0, stat} :
    ra == OFS_MEMW        ? {2'h0, mem_wdata} :
    ra[7:5] == IDX_PAGE   ? {17'h0, idx[ra[4:2]]} : 32'h0;

  // Bus slave: zero wait states, read data loaded at address phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      wr_pend <= addr_ok && hwrite && hit;
      wr_addr <= ra;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // Shift count uses the low six operand bits only.
  wire [5:0]  cnt  = oper[5:0];
  wire [89:0] rs3  = {sum, sum, sum} << cnt;
  wire [89:0] re3  = {ext, ext, ext} << cnt;
  wire [119:0] rp2 = {sum, ext, sum, ext} << cnt;

  // Signed operand views for compare.
  wire signed [30:0] vy = oc_val(oper);
  wire signed [30:0] vs = oc_val(sum);
  wire signed [30:0] ve = oc_val(ext);

  // Magnitudes for multiply and divide.
  wire [28:0] my  = oper[29] ? ~oper[28:0] : oper[28:0];
  wire [28:0] me  = ext[29] ? ~ext[28:0] : ext[28:0];
  wire [57:0] pm  = me * my;
  wire [59:0] pr  = (ext[29] ^ oper[29]) ? ~{2'h0, pm} : {2'h0, pm};
  wire [58:0] dm  = sum[29] ? ~{sum[28:0], ext} : {sum[28:0], ext};
  wire        dsg = sum[29] ^ oper[29];
  wire        div_fault = (my == 29'h0) || (dm[58:29] >= {1'b0, my});
  wire [58:0] quo = (my == 29'h0) ? 59'h0 : dm / {30'h0, my};
  wire [58:0] rem = (my == 29'h0) ? 59'h0 : dm % {30'h0, my};

  // Adder inputs shared by the add-style codes.
  wire        is_sub = cmd.op == OP_SUB || cmd.op == OP_RSUB || cmd.op == OP_SUB_E;
  wire [29:0] addend = is_sub ? ~oper : oper;
  wire [29:0] sum_r  = oc_add(sum, addend);
  wire [29:0] ext_r  = oc_add(ext, addend);

  logic [29:0] next_sum;          // Sum after this command.
  logic [29:0] next_ext;          // Extension after this command.
  logic        next_skip;         // Skip the next instruction.
  logic        next_fault;        // Divide fault seen.
  logic        next_mem_we;       // Write a word to memory.
  logic [29:0] next_mem_wdata;    // Word for memory.
  logic        next_ef;           // Send a function word.
  logic        next_ack;          // Acknowledge channel input.
  logic        next_idx_we;       // Load an index register.

  // Execution of one command per go cycle.
  always_comb begin
    next_sum       = sum;
    next_ext       = ext;
    next_skip      = 1'b0;
    next_fault     = 1'b0;
    next_mem_we    = 1'b0;
    next_mem_wdata = mem_wdata;
    next_ef        = 1'b0;
    next_ack       = 1'b0;
    next_idx_we    = 1'b0;
    case (cmd.op)
      OP_RSH_S: next_sum = 30'($signed(sum) >>> cnt);
      OP_RSH_P: {next_sum, next_ext} = 60'($signed({sum, ext}) >>> cnt);
      OP_LSH_E: next_ext = re3[89:60];
      OP_LSH_S: next_sum = rs3[89:60];
      OP_LSH_P: {next_sum, next_ext} = rp2[119:60];
      OP_CMP: begin
        case (cmd.j)
          3'h0:    next_skip = 1'b0;
          3'h1:    next_skip = 1'b1;
          3'h2:    next_skip = vy <= ve;
          3'h3:    next_skip = vy > ve;
          3'h4:    next_skip = (ve >= vy) && (vy > vs);
          3'h5:    next_skip = (vy > ve) || (vy <= vs);
          3'h6:    next_skip = vy <= vs;
          default: next_skip = vy > vs;
        endcase
      end
      OP_ENT_E: next_ext = oper;
      OP_ENT_S: next_sum = oper;
      OP_ENT_X: next_idx_we = 1'b1;
      OP_EXTF: begin
        if (cmd.j[2:1] == 2'h0) begin
          next_skip = act_s2[cmd.j[0]];
        end else begin
          next_ef = 1'b1;
        end
      end
      OP_STO_E: begin
        if (cmd.k == K_ZERO) begin
          next_ext = ~ext;
        end else if (cmd.k == K_FOUR) begin
          next_sum = ext;
        end else begin
          next_mem_we    = 1'b1;
          next_mem_wdata = ext;
        end
      end
      OP_STO_S: begin
        if (cmd.k == K_FOUR) begin
          next_sum = ~sum;
        end else if (cmd.k == K_ZERO) begin
          next_ext = sum;
        end else begin
          next_mem_we    = 1'b1;
          next_mem_wdata = sum;
        end
      end
      OP_STO_X: begin
        next_mem_we    = 1'b1;
        next_mem_wdata = {15'h0, idx[cmd.j]};
      end
      OP_STO_C: begin
        next_mem_we    = 1'b1;
        next_mem_wdata = inw_s2;
        next_ack       = 1'b1;
      end
      OP_ADD, OP_SUB: next_sum = sum_r;
      OP_MUL: begin
        {next_sum, next_ext} = pr;
        next_skip = (cmd.j == 3'h1) || (cmd.j == 3'h4 && pr[59:30] == 30'h0);
      end
      OP_DIV: begin
        next_fault = div_fault;
        if (!div_fault) begin
          next_ext = dsg ? {1'b1, ~quo[28:0]} : {1'b0, quo[28:0]};
          next_sum = dsg ? {1'b1, ~rem[28:0]} : {1'b0, rem[28:0]};
        end
        next_skip = (cmd.j == 3'h1) || (cmd.j == 3'h3 && div_fault) ||
                    (cmd.j == 3'h2 && !div_fault);
      end
      // replace writes the new sum back
      OP_RADD, OP_RSUB: begin
        next_sum       = sum_r;
        next_mem_we    = 1'b1;
        next_mem_wdata = sum_r;
      end
      OP_ADD_E, OP_SUB_E: begin
        next_ext = ext_r;
        case (cmd.j)
          3'h0:    next_skip = 1'b0;
          3'h1:    next_skip = 1'b1;
          3'h2:    next_skip = !sum[29];
          3'h3:    next_skip = sum[29];
          3'h4:    next_skip = ext_r == 30'h0 || ext_r == 30'h3FFFFFFF;
          3'h5:    next_skip = !(ext_r == 30'h0 || ext_r == 30'h3FFFFFFF);
          3'h6:    next_skip = !ext_r[29];
          default: next_skip = ext_r[29];
        endcase
      end
      default: next_skip = 1'b0;
    endcase
  end

  // Index file, one loader per entry.
  for (genvar gi = 0; gi < NUM_IDX; gi++) begin : g_idx
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        idx[gi] <= 15'h0;
      end else if (ce) begin
        if (go && next_idx_we && cmd.j == 3'(gi)) begin
          idx[gi] <= oper[14:0];
        end else if (we_idx && wr_addr[4:2] == 3'(gi)) begin
          idx[gi] <= hwdata[14:0];
        end
      end
    end
  end

  // Working registers: execution first, then bus writes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sum  <= 30'h0;
      ext  <= 30'h0;
      oper <= 30'h0;
      cmd  <= '0;
      go   <= 1'b0;
    end else if (ce) begin
      go <= we_ctrl;
      if (we_ctrl) cmd <= sae_cmd_type'(hwdata[11:0]);
      if (we_oper) oper <= hwdata[29:0];
      if (go) begin
        sum <= next_sum;
        ext <= next_ext;
      end else begin
        if (we_sum) sum <= hwdata[29:0];
        if (we_ext) ext <= hwdata[29:0];
      end
    end
  end

  // Result strobes and status.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat      <= 3'h0;
      skip      <= 1'b0;
      done      <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 15'h0;
      mem_wdata <= 30'h0;
      ef_strobe <= 1'b0;
      ef_word   <= 30'h0;
      chan_sel  <= 3'h0;
      in_ack    <= 1'b0;
    end else if (ce) begin
      done      <= go;
      skip      <= go && next_skip;
      mem_we    <= go && next_mem_we;
      ef_strobe <= go && next_ef;
      in_ack    <= go && next_ack;
      stat[ST_BUSY] <= we_ctrl;
      if (go) begin
        stat[ST_SKIP]  <= next_skip;
        stat[ST_FAULT] <= next_fault;
        mem_addr       <= oper[14:0];
        mem_wdata      <= next_mem_wdata;
        chan_sel       <= cmd.j;
        if (next_ef) ef_word <= oper;
      end
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_rsh;
    ce && go && cmd.op == OP_RSH_S |=> sum == 30'($signed($past(sum)) >>> $past(oper[5:0]));
  endproperty
  a_rsh: assert property (p_rsh) else $error("right shift wrong");

  property p_cmp;
    ce && go && cmd.op == OP_CMP |=> sum == $past(sum) && ext == $past(ext)
      && ($past(cmd.j) == 3'h1 ? skip : 1'b1) && ($past(cmd.j) == 3'h0 ? !skip : 1'b1);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare wrong");

  property p_ent;
    ce && go && cmd.op == OP_ENT_S |=> sum == $past(oper) && done;
  endproperty
  a_ent: assert property (p_ent) else $error("enter wrong");

  property p_stx;
    ce && go && cmd.op == OP_STO_X |=> mem_we && mem_wdata[29:15] == 15'h0;
  endproperty
  a_stx: assert property (p_stx) else $error("index store wrong");

  property p_stc;
    ce && go && cmd.op == OP_STO_C |=> in_ack && mem_we && mem_wdata == $past(inw_s2);
  endproperty
  a_stc: assert property (p_stc) else $error("channel store wrong");

  property p_add;
    ce && go && cmd.op == OP_ADD |=> sum == oc_add($past(sum), $past(oper));
  endproperty
  a_add: assert property (p_add) else $error("add wrong");

  property p_div;
    ce && go && cmd.op == OP_DIV && cmd.j == 3'h3 |=> skip == stat[ST_FAULT];
  endproperty
  a_div: assert property (p_div) else $error("divide skip wrong");

  property p_adde;
    ce && go && (cmd.op == OP_ADD_E || cmd.op == OP_SUB_E) |=> sum == $past(sum);
  endproperty
  a_adde: assert property (p_adde) else $error("extension op changed sum");

  property p_mul;
    ce && go && cmd.op == OP_MUL && cmd.j == 3'h4 |=> skip == (sum == 30'h0);
  endproperty
  a_mul: assert property (p_mul) else $error("multiply skip wrong");

  property p_stoe;
    ce && go && cmd.op == OP_STO_E && cmd.k == K_ZERO |=> ext == ~$past(ext) && !mem_we;
  endproperty
  a_stoe: assert property (p_stoe) else $error("extension complement wrong");

endmodule : sae_unit

// ===== dv/sae_chan_model.sv
// Far-side channel model: peer activity bits and one input channel word.
module sae_chan_model
  import sae_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        in_ack,
  input  wire logic        load,
  input  wire logic [1:0]  act_set,
  input  wire logic [29:0] word_set,
  output logic      [1:0]  peer_active,
  output logic      [29:0] in_word,
  output int               n_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  assign peer_active = act_set;

  // The word stays put until taken, then is retired so a stale copy cannot pass.
  // word held until acknowledge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_word <= 30'h0;
      n_ack   <= 0;
    end else if (load) begin
      in_word <= word_set;
    end else if (in_ack === 1'b1) begin
      in_word <= ~in_word;
      n_ack   <= n_ack + 1;
    end
  end
endmodule : sae_chan_model

// ===== dv/tb.sv
// Bench: register-driven commands, table of ordinary cases, then odd cases.
module tb
  import sae_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // One table row: command, operand, start pair, expected pair and skip.
  typedef struct packed {
    logic [5:0]  op;
    logic [2:0]  j;
    logic [2:0]  k;
    logic [29:0] y;
    logic [29:0] s;
    logic [29:0] e;
    logic [29:0] xs;
    logic [29:0] xe;
    logic        xk;
  } sae_row_type;

  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        load = 1'b0;
  logic [1:0]  act_set = 2'h0;
  logic [29:0] word_set = 30'h0;
  logic [31:0] hrdata, q;
  logic        hreadyout, hresp, in_ack, ef_strobe, mem_we, skip, done;
  logic [29:0] in_word, ef_word, mem_wdata;
  logic [1:0]  peer_active;
  logic [2:0]  chan_sel;
  logic [14:0] mem_addr;
  int          n_fail = 0;
  int          tests_run = 0;
  int          n_done = 0;
  int          n_we = 0;
  int          n_ef = 0;
  int          n_skip = 0;
  int          n_ack, c;

  sae_row_type rows [17] = '{
    '{OP_RSH_S, 3'h0, K_FULL, 30'h3FFFFFC2, 30'h20000000, 30'h12345, 30'h38000000, 30'h12345, 1'b0},
    '{OP_RSH_P, 3'h0, K_FULL, 30'h4, 30'h3, 30'h0, 30'h0, 30'h0C000000, 1'b0},
    '{OP_LSH_E, 3'h0, K_FULL, 30'h1, 30'h5, 30'h20000001, 30'h5, 30'h3, 1'b0},
    '{OP_LSH_S, 3'h0, K_FULL, 30'h2, 30'h30000000, 30'h0, 30'h3, 30'h0, 1'b0},
    '{OP_LSH_P, 3'h0, K_FULL, 30'h1, 30'h20000000, 30'h1, 30'h0, 30'h3, 1'b0},
    '{OP_ENT_E, 3'h0, K_FULL, 30'h7, 30'h1, 30'h3FFFFFFF, 30'h1, 30'h7, 1'b0},
    '{OP_ENT_S, 3'h0, K_FULL, 30'h3FFFFFF0, 30'h5, 30'h2, 30'h3FFFFFF0, 30'h2, 1'b0},
    '{OP_ADD, 3'h0, K_FULL, 30'h3, 30'h3FFFFFFE, 30'h0, 30'h2, 30'h0, 1'b0},
    '{OP_SUB, 3'h0, K_FULL, 30'h5, 30'h5, 30'h0, 30'h3FFFFFFF, 30'h0, 1'b0},
    '{OP_MUL, 3'h4, K_FULL, 30'h4, 30'h0, 30'h3, 30'h0, 30'hC, 1'b1},
    '{OP_DIV, 3'h2, K_FULL, 30'h2, 30'h0, 30'h7, 30'h1, 30'h3, 1'b1},
    '{OP_ADD_E, 3'h4, K_FULL, 30'h3FFFFFFC, 30'h9, 30'h3, 30'h9, 30'h3FFFFFFF, 1'b1},
    '{OP_SUB_E, 3'h7, K_FULL, 30'h5, 30'h9, 30'h2, 30'h9, 30'h3FFFFFFC, 1'b1},
    '{OP_STO_E, 3'h0, K_ZERO, 30'h0, 30'h1, 30'h5, 30'h1, 30'h3FFFFFFA, 1'b0},
    '{OP_STO_E, 3'h0, K_FOUR, 30'h0, 30'h1, 30'h5, 30'h5, 30'h5, 1'b0},
    '{OP_STO_S, 3'h0, K_FOUR, 30'h0, 30'h5, 30'h2, 30'h3FFFFFFA, 30'h2, 1'b0},
    '{OP_STO_S, 3'h0, K_ZERO, 30'h0, 30'h11, 30'h2, 30'h11, 30'h11, 1'b0}};

  sae_unit i_sae_unit (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .peer_active(peer_active),
    .in_word(in_word), .in_ack(in_ack), .ef_strobe(ef_strobe), .ef_word(ef_word),
    .chan_sel(chan_sel), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .skip(skip), .done(done));

  sae_chan_model i_sae_chan_model (.hclk(hclk), .hresetn(hresetn), .in_ack(in_ack),
    .load(load), .act_set(act_set), .word_set(word_set), .peer_active(peer_active),
    .in_word(in_word), .n_ack(n_ack));

  // Free-running clock at 4 ns.
  always #2 hclk = ~hclk;

  // Counts one-cycle pulses as they are sampled.
  always @(posedge hclk) begin
    n_done += (done === 1'b1);
    n_we   += (mem_we === 1'b1);
    n_ef   += (ef_strobe === 1'b1);
    n_skip += (skip === 1'b1);
  end

  // Compares a whole word.
  task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_word

  // Compares a single flag.
  task automatic chk_bit(input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_bit

  // One single AHB-Lite transfer; the address phase is held until hready.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  // Loads operand, starts the command and waits a bounded time for done.
  task automatic run(input logic [5:0] op, input logic [2:0] j, input logic [2:0] k,
                     input logic [29:0] y);
    int d0;
    d0 = n_done;
    bus(1'b1, {24'h0, OFS_OPER}, {2'h0, y}, q);
    bus(1'b1, {24'h0, OFS_CTRL}, {20'h0, k, j, op}, q);
    for (int i = 0; i < 20 && n_done == d0; i++) @(posedge hclk);
    // One more edge lets the pulse counters and the far side settle.
    @(posedge hclk);
    chk_bit(1'b1, n_done != d0);
  endtask : run

  // Prints counts and verdict, then ends the run.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // Cuts a hang short.
  initial begin
    #100000;
    n_fail++;
    summarize();
  end

  // Main sequence.
  initial begin
    repeat (16) @(posedge hclk);
    chk_bit(1'b1, hreadyout);
    chk_word(32'h0, {27'h0, done, skip, mem_we, in_ack, ef_strobe});
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, {24'h0, OFS_SUM}, {2'h0, rows[i].s}, q);
      bus(1'b1, {24'h0, OFS_EXT}, {2'h0, rows[i].e}, q);
      run(rows[i].op, rows[i].j, rows[i].k, rows[i].y);
      bus(1'b0, {24'h0, OFS_SUM}, 32'h0, q);
      chk_word({2'h0, rows[i].xs}, q);
      bus(1'b0, {24'h0, OFS_EXT}, 32'h0, q);
      chk_word({2'h0, rows[i].xe}, q);
      bus(1'b0, {24'h0, OFS_STAT}, 32'h0, q);
      chk_bit(rows[i].xk, q[ST_SKIP]);
    end
    // Every compare condition against sum 2, extension 6, operand 4.
    bus(1'b1, {24'h0, OFS_SUM}, 32'h2, q);
    bus(1'b1, {24'h0, OFS_EXT}, 32'h6, q);
    for (int j = 0; j < 8; j++) begin
      run(OP_CMP, 3'(j), K_FULL, 30'h4);
      bus(1'b0, {24'h0, OFS_STAT}, 32'h0, q);
      chk_bit(1'(8'h96 >> j), q[ST_SKIP]);
    end
    bus(1'b0, {24'h0, OFS_SUM}, 32'h0, q);
    chk_word(32'h2, q);
    // Divide fault: high half not below divisor.
    bus(1'b1, {24'h0, OFS_SUM}, 32'h5, q);
    run(OP_DIV, 3'h3, K_FULL, 30'h2);
    bus(1'b0, {24'h0, OFS_STAT}, 32'h0, q);
    chk_word(32'h3, {30'h0, q[ST_FAULT], q[ST_SKIP]});
    // Index load ignores high operand bits; store zero-extends it.
    run(OP_ENT_X, 3'h3, K_FULL, 30'h3FFF1234);
    bus(1'b0, 32'h2C, 32'h0, q);
    chk_word(32'h1234, q);
    c = n_we;
    run(OP_STO_X, 3'h3, K_FULL, 30'h100);
    chk_word({2'h0, 30'h1234}, {2'h0, mem_wdata});
    chk_word(32'h100, {17'h0, mem_addr});
    chk_bit(1'b1, n_we == c + 1);
    // Replace add then subtract, each written back.
    bus(1'b1, {24'h0, OFS_SUM}, 32'h1, q);
    run(OP_RADD, 3'h0, K_FULL, 30'h2);
    chk_word(32'h3, {2'h0, mem_wdata});
    run(OP_RSUB, 3'h0, K_FULL, 30'h1);
    chk_word(32'h2, {2'h0, mem_wdata});
    // Plain store of the extension goes to memory.
    c = n_we;
    run(OP_STO_E, 3'h0, K_FULL, 30'h55);
    chk_word(32'h6, {2'h0, mem_wdata});
    chk_word(32'h55, {17'h0, mem_addr});
    chk_bit(1'b1, n_we == c + 1);
    // Clock enable low holds a started add until it rises.
    bus(1'b1, {24'h0, OFS_OPER}, 32'h4, q);
    c = n_done;
    bus(1'b1, {24'h0, OFS_CTRL}, {20'h0, K_FULL, 3'h0, OP_ADD}, q);
    ce <= 1'b0;
    repeat (4) @(posedge hclk);
    chk_bit(1'b1, n_done == c);
    ce <= 1'b1;
    for (int i = 0; i < 20 && n_done == c; i++) @(posedge hclk);
    @(posedge hclk);
    chk_bit(1'b1, n_done == c + 1);
    bus(1'b0, {24'h0, OFS_SUM}, 32'h0, q);
    chk_word(32'h6, q);
    // Peer activity test on channels 0 and 1.
    act_set <= 2'h3;
    c = n_skip;
    run(OP_EXTF, 3'h0, K_FULL, 30'h0);
    chk_bit(1'b1, n_skip == c + 1);
    bus(1'b0, {24'h0, OFS_STAT}, 32'h0, q);
    chk_bit(1'b1, q[ST_SKIP]);
    act_set <= 2'h0;
    run(OP_EXTF, 3'h1, K_FULL, 30'h0);
    bus(1'b0, {24'h0, OFS_STAT}, 32'h0, q);
    chk_bit(1'b0, q[ST_SKIP]);
    // Function word out on channel 5.
    c = n_ef;
    run(OP_EXTF, 3'h5, K_FULL, 30'h2AAAAAAA);
    chk_word({2'h0, 30'h2AAAAAAA}, {2'h0, ef_word});
    chk_word(32'h5, {29'h0, chan_sel});
    chk_bit(1'b1, n_ef == c + 1);
    // Channel word stored, then acknowledged once.
    load     <= 1'b1;
    word_set <= 30'h15555555;
    @(posedge hclk);
    load <= 1'b0;
    c = n_ack;
    run(OP_STO_C, 3'h2, K_FULL, 30'h40);
    chk_word({2'h0, 30'h15555555}, {2'h0, mem_wdata});
    chk_bit(1'b1, n_ack == c + 1);
    // Mid-run reset clears the working registers and the index file.
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk_word(32'h20, {26'h0, hreadyout, done, skip, mem_we, in_ack, ef_strobe});
    hresetn <= 1'b1;
    bus(1'b0, {24'h0, OFS_SUM}, 32'h0, q);
    chk_word(32'h0, q);
    bus(1'b0, 32'h2C, 32'h0, q);
    chk_word(32'h0, q);
    // Unmapped address reads zero.
    bus(1'b0, 32'h100, 32'h0, q);
    chk_word(32'h0, q);
    chk_bit(1'b0, hresp);
    summarize();
  end
endmodule : tb
